// *** sadc_pkg.sv ***
// Purpose: shared constants and types for the serial converter link
// Assumes: 40 MHz ref_clk on both ends
// Notes:   counts are in link clock edges after the select falls
package sadc_pkg;

  localparam int          WORD_W   = 10;
  localparam int          FRAME_W  = 16;
  localparam int          CNT_W    = 5;
  localparam int          CLK_MHZ  = 40;

  // falling- and rising-edge marks inside one frame
  localparam logic [4:0]  FALL_MODE_KEEP  = 5'h02;
  localparam logic [4:0]  FALL_SHUT_LIMIT = 5'h0a;
  localparam logic [4:0]  FALL_FRAME_END  = 5'h10;
  localparam logic [4:0]  RISE_TRACK      = 5'h0d;
  localparam logic [3:0]  BIT_TOP         = 4'hf;
  localparam logic [2:0]  LEAD_PAD        = 3'h0;
  localparam logic [2:0]  TRAIL_PAD       = 3'h0;

  // host frame plan, counted in rising link clock edges
  // slots 0..2 are leading zeros, so data sits in slots 3..12
  localparam logic [4:0]  RISE_FIRST_DATA = 5'h03;
  localparam logic [4:0]  RISE_LAST_DATA  = 5'h0c;
  localparam logic [4:0]  RISE_END_FULL   = 5'h11;
  localparam logic [4:0]  RISE_END_SHUT   = 5'h05;
  localparam logic [4:0]  FRAME_CYCLES    = 5'h14;

  // times in ns and their cycle counts
  localparam int SCLK_PERIOD_NS        = 500;
  localparam int TRACK_TIME_MIN_NS     = 350;
  localparam int INTERFRAME_GAP_TIME_NS = 50;
  localparam int SCLK_HALF_INT  = (SCLK_PERIOD_NS * CLK_MHZ) / 2000;
  localparam int GAP_INT =
    ((INTERFRAME_GAP_TIME_NS + TRACK_TIME_MIN_NS) * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  SCLK_HALF_CYC = 8'(SCLK_HALF_INT);
  localparam logic [7:0]  GAP_CYC       = 8'(GAP_INT);

  localparam logic [1:0]  FIFO_DEPTH    = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h1,
    MODE_SHUT   = 2'h2
  } sadc_mode_e;

  typedef enum logic [1:0] {
    HST_IDLE = 2'h1,
    HST_RUN  = 2'h2
  } sadc_hst_e;

endpackage : sadc_pkg

// *** sadc_if.sv ***
// Purpose: three-wire link between host and converter ends
// Assumes: host drives select and clock, converter drives data
// Notes:   a released data line shows the inverse of the last bit
interface sadc_if;
  logic frame_sel_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  wire  serial_result_out_line;

  // released line inverts the last bit, so a late sample shows up as a wrong bit
  assign serial_result_out_line = serial_result_oe ? serial_result_out : ~serial_result_out;

  modport dev (
    input  frame_sel_n,
    input  sclk,
    output serial_result_out,
    output serial_result_oe
  );

  modport host (
    output frame_sel_n,
    output sclk,
    input  serial_result_out_line
  );
endinterface : sadc_if

// *** sadc_dev.sv ***
// Purpose: converter end: frame decode, mode and power control, shifter
// Assumes: link pins are asynchronous to ref_clk and are synchronised
// Notes:   analog_code stands in for the converted input value
module sadc_dev
  import sadc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  sadc_if.dev                     link,
  input  wire logic [WORD_W-1:0]  analog_code,
  output      logic               shutdown_mode,
  output      logic               powered_up,
  output      logic               track_mode,
  output      logic               frame_active
);

  // power-on mode is unknown on the real part; pick one here
  parameter logic PWRUP_SHUT = 1'b0;

  typedef struct packed {
    logic [1:0]         cs_sync;
    logic [1:0]         ck_sync;
    logic               cs_prev;
    logic               ck_prev;
    sadc_mode_e         mode;
    sadc_mode_e         mode_at_start;
    logic               in_frame;
    logic               powered;
    logic               dummy_frame;
    logic               track;
    logic [CNT_W-1:0]   falls;
    logic [CNT_W-1:0]   rises;
    logic [FRAME_W-1:0] word;
    logic               sdo;
    logic               sdo_oe;
  } sadc_dev_s;

  sadc_dev_s q;
  sadc_dev_s d;

  // picks the bit that belongs to a given falling edge, msb first
  function automatic logic word_bit(
    input logic [FRAME_W-1:0] w,
    input logic [CNT_W-1:0]   idx
  );
    return w[BIT_TOP - idx[3:0]];
  endfunction : word_bit

  logic cs_s;
  logic ck_s;
  logic cs_fall;
  logic cs_rise;
  logic ck_fall;
  logic ck_rise;
  logic [CNT_W-1:0] falls_n;
  logic [CNT_W-1:0] rises_n;

  // edges are taken from the second sync stage only
  assign cs_s    = q.cs_sync[1];
  assign ck_s    = q.ck_sync[1];
  assign cs_fall = q.cs_prev & ~cs_s;
  assign cs_rise = ~q.cs_prev & cs_s;
  assign ck_fall = q.ck_prev & ~ck_s;
  assign ck_rise = ~q.ck_prev & ck_s;
  assign falls_n = q.falls + 5'h01;
  assign rises_n = q.rises + 5'h01;

  // next-state logic for the whole end
  always_comb begin
    d = q;
    d.cs_sync[0] = link.frame_sel_n;
    d.cs_sync[1] = q.cs_sync[0];
    d.ck_sync[0] = link.sclk;
    d.ck_sync[1] = q.ck_sync[0];
    d.cs_prev    = cs_s;
    d.ck_prev    = ck_s;

    if (cs_fall) begin
      // a select fall always wins over a clock edge in the same cycle
      d.in_frame      = 1'b1;
      d.falls         = '0;
      d.rises         = '0;
      d.mode_at_start = q.mode;
      d.mode          = MODE_NORMAL;
      d.track         = 1'b0;
      // waking from shutdown, or never settled since reset
      d.dummy_frame   = ~q.powered | (q.mode == MODE_SHUT);
      if (q.mode == MODE_SHUT) begin
        d.powered = 1'b0;
      end
      // a dummy frame carries no usable code, so send zeros
      if (d.dummy_frame) begin
        d.word = {LEAD_PAD, {WORD_W{1'b0}}, TRAIL_PAD};
      end else begin
        d.word = {LEAD_PAD, analog_code, TRAIL_PAD};
      end
      d.sdo    = word_bit(d.word, '0);
      d.sdo_oe = 1'b1;
    end else if (q.in_frame && cs_rise) begin
      // frame closed by the host; decide mode from the fall count
      d.in_frame = 1'b0;
      d.sdo_oe   = 1'b0;
      d.track    = 1'b1;
      if (q.falls < FALL_MODE_KEEP) begin
        d.mode = q.mode_at_start;
      end else if (q.falls < FALL_SHUT_LIMIT) begin
        d.mode = MODE_SHUT;
      end else begin
        d.mode = MODE_NORMAL;
      end
    end else if (q.in_frame) begin
      // counts saturate so an idle-low select cannot wrap them
      if (ck_fall && q.falls < FALL_FRAME_END) begin
        d.falls = falls_n;
        if (falls_n == FALL_FRAME_END) begin
          d.sdo_oe = 1'b0;
          if (q.dummy_frame) begin
            d.powered = 1'b1;
          end
        end else begin
          d.sdo = word_bit(q.word, falls_n);
        end
      end
      if (ck_rise && q.rises < FALL_FRAME_END) begin
        d.rises = rises_n;
        if (rises_n == RISE_TRACK) begin
          d.track = 1'b1;
        end
      end
    end
  end

  // state register; clk_en freezes everything
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q.cs_sync       <= 2'h3;
      q.ck_sync       <= 2'h3;
      q.cs_prev       <= 1'b1;
      q.ck_prev       <= 1'b1;
      q.mode          <= PWRUP_SHUT ? MODE_SHUT : MODE_NORMAL;
      q.mode_at_start <= MODE_NORMAL;
      q.in_frame      <= 1'b0;
      q.powered       <= 1'b0;
      q.dummy_frame   <= 1'b0;
      q.track         <= 1'b1;
      q.falls         <= '0;
      q.rises         <= '0;
      q.word          <= '0;
      q.sdo           <= 1'b0;
      q.sdo_oe        <= 1'b0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // link pins and status come straight from flops, except shutdown_mode, decoded from the mode flops
  assign link.serial_result_out = q.sdo;
  assign link.serial_result_oe  = q.sdo_oe;
  assign shutdown_mode          = (q.mode == MODE_SHUT);
  assign powered_up             = q.powered;
  assign track_mode             = q.track;
  assign frame_active           = q.in_frame;

endmodule : sadc_dev

// *** sadc_host.sv ***
// Purpose: host end: makes select and link clock, reads words into a buffer
// Assumes: serial_result_out_line is asynchronous and passes two flops
// Notes:   a full buffer holds off the next conversion frame, so no word is lost
module sadc_host
  import sadc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  sadc_if.host                    link,
  input  wire logic               conv_req,
  input  wire logic               shutdown_req,
  output      logic [WORD_W-1:0]  word_data,
  output      logic               word_valid,
  input  wire logic               word_ready,
  output      logic               conv_ready,
  output      logic               link_busy,
  output      logic               dummy_pending
);

  typedef struct packed {
    logic [1:0]              sd_sync;
    sadc_hst_e               state;
    logic                    cs_n;
    logic                    sclk;
    logic [7:0]              div;
    logic [7:0]              gap;
    logic [CNT_W-1:0]        rcnt;
    logic                    shut_frame;
    logic                    dummy;
    logic [WORD_W-1:0]       shreg;
    logic [1:0][WORD_W-1:0]  mem;
    logic                    wr;
    logic                    rd;
    logic [1:0]              count;
  } sadc_hst_s;

  sadc_hst_s q;
  sadc_hst_s d;

  logic             wrap;
  logic             rise_now;
  logic             room;
  logic             gap_ok;
  logic             start;
  logic             push;
  logic             pop;
  logic [CNT_W-1:0] n;

  // free-running divider keeps a falling edge ahead of every select fall
  assign wrap     = (q.div == SCLK_HALF_CYC - 8'h01);
  assign rise_now = wrap & ~q.sclk;
  assign room     = (q.count < FIFO_DEPTH);
  assign gap_ok   = (q.gap >= GAP_CYC);
  assign start    = gap_ok & (shutdown_req | (conv_req & room));
  assign pop      = word_valid & word_ready;
  assign n        = q.rcnt + 5'h01;

  always_comb begin
    d = q;
    push = 1'b0;
    d.sd_sync[0] = link.serial_result_out_line;
    d.sd_sync[1] = q.sd_sync[0];
    d.div  = wrap ? 8'h00 : q.div + 8'h01;
    d.sclk = wrap ? ~q.sclk : q.sclk;
    if (q.cs_n && !gap_ok) begin
      d.gap = q.gap + 8'h01;
    end

    if (rise_now) begin
      unique case (q.state)
        HST_IDLE: begin
          if (start) begin
            d.state      = HST_RUN;
            d.cs_n       = 1'b0;
            d.gap        = 8'h00;
            d.rcnt       = '0;
            d.shut_frame = shutdown_req;
          end
        end
        HST_RUN: begin
          // capture on rising edges what the converter set on falls
          if (!q.cs_n && n >= RISE_FIRST_DATA && n <= RISE_LAST_DATA) begin
            d.shreg = {q.shreg[WORD_W-2:0], q.sd_sync[1]};
          end
          if (n == (q.shut_frame ? RISE_END_SHUT : RISE_END_FULL)) begin
            d.cs_n = 1'b1;
            // shut frame ends between falls 5 and 6
            if (q.shut_frame) begin
              d.dummy = 1'b1;
            end else begin
              push    = ~q.dummy;
              d.dummy = 1'b0;
            end
          end
          if (n == FRAME_CYCLES) begin
            // twenty whole cycles per frame, even count
            d.rcnt = '0;
            if (start) begin
              d.cs_n       = 1'b0;
              d.gap        = 8'h00;
              d.shut_frame = shutdown_req;
            end else begin
              d.state = HST_IDLE;
            end
          end else begin
            d.rcnt = n;
          end
        end
        default: d.state = HST_IDLE;
      endcase
    end

    // two-entry buffer; a conversion frame only starts when a slot is free
    if (push) begin
      d.mem[q.wr] = d.shreg;
      d.wr        = ~q.wr;
    end
    if (pop) begin
      d.rd = ~q.rd;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q.sd_sync    <= 2'h0;
      q.state      <= HST_IDLE;
      q.cs_n       <= 1'b1;
      q.sclk       <= 1'b1;
      q.div        <= 8'h00;
      q.gap        <= 8'h00;
      q.rcnt       <= '0;
      q.shut_frame <= 1'b0;
      q.dummy      <= 1'b1;
      q.shreg      <= '0;
      q.mem        <= '0;
      q.wr         <= 1'b0;
      q.rd         <= 1'b0;
      q.count      <= 2'h0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign link.frame_sel_n = q.cs_n;
  assign link.sclk        = q.sclk;
  assign word_data        = q.mem[q.rd];
  assign word_valid       = (q.count != 2'h0);
  assign conv_ready       = room;
  assign link_busy        = (q.state == HST_RUN);
  assign dummy_pending    = q.dummy;

endmodule : sadc_host

// *** sadc_monitor.sv ***
// Purpose: checks timing relations on the link joining host and converter
// Assumes: link pins change only on ref_clk edges
// Notes:   the fall count restarts at every select fall
module sadc_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  logic       sel_q;
  logic       sclk_q;
  logic [4:0] falls_q;
  logic [9:0] since_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // saturating counters, so a long idle never wraps into a false short gap
  always_ff @(posedge ref_clk) begin
    sel_q  <= frame_sel_n;
    sclk_q <= sclk;
    if (!reset_n) begin
      falls_q <= 5'h00;
      since_q <= 10'h3ff;
    end else if (sel_q && !frame_sel_n) begin
      falls_q <= 5'h00;
      since_q <= 10'h000;
    end else begin
      if (!frame_sel_n && sclk_q && !sclk && falls_q != 5'h10) falls_q <= falls_q + 5'h01;
      if (since_q != 10'h3ff) since_q <= since_q + 10'h001;
    end
  end

  property p_oe_on_fall;
    $fell(frame_sel_n) |-> ##[2:4] serial_result_oe;
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("data not driven after select fall");
  property p_oe_off_rise;
    $rose(frame_sel_n) |-> ##[1:4] !serial_result_oe;
  endproperty
  a_oe_off_rise: assert property (p_oe_off_rise) else $error("data not released after select rise");
  property p_oe_off16;
    (falls_q == 5'h10) [*5] |-> !serial_result_oe;
  endproperty
  a_oe_off16: assert property (p_oe_off16) else $error("data still driven after sixteen falls");
  property p_idle_off;
    frame_sel_n [*5] |-> !serial_result_oe;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("data driven outside a frame");
  property p_pad_zero;
    sclk && !sclk_q && serial_result_oe && (falls_q inside {5'h01, 5'h02, 5'h0d, 5'h0e, 5'h0f}) |-> !serial_result_out;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("padding bit not zero");
  property p_data_edge;
    serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out) |-> !sclk;
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data changed while link clock high");
  property p_fall_space;
    $fell(frame_sel_n) |-> sclk && since_q >= 10'h12c;
  endproperty
  a_fall_space: assert property (p_fall_space) else $error("select falls too close or clock low");
  property p_quiet_gap;
    $rose(frame_sel_n) |-> frame_sel_n [*8];
  endproperty
  a_quiet_gap: assert property (p_quiet_gap) else $error("select fell inside the quiet gap");
endmodule : sadc_monitor

// *** tb.sv ***
// Purpose: runs host and converter ends together plus a bench-driven converter end
// Assumes: host link clock of twenty ref cycles, bench link clock of eight
// Notes:   the second link ends frames at counts the host never uses
module tb
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] CODES [5] = '{10'h000, 10'h001, 10'h200, 10'h3ff, 10'h2a5};
  localparam int         FALLS [8] = '{1, 4, 1, 4, 12, 16, 12, 16};
  localparam logic       SHUT  [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam int         LINK2_HALF = 4;  // half of the 200 ns bench link clock
  logic              ref_clk;
  logic              reset_n;
  logic              conv_req;
  logic              shutdown_req;
  logic              word_ready;
  logic [WORD_W-1:0] analog_code;
  logic [WORD_W-1:0] word_data;
  logic              word_valid;
  logic              conv_ready;
  logic              link_busy;
  logic              dummy_pending;
  logic              shutdown_mode;
  logic              powered_up;
  logic              track_mode;
  logic              frame_active;
  logic              shut2;
  logic              pwr2;
  logic              clk_en2;
  int                mismatches = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  sadc_if lnk ();
  sadc_if lnk2 ();
  sadc_host sadc_host_inst (.ref_clk, .reset_n, .clk_en(1'b1), .link(lnk), .conv_req, .shutdown_req,
    .word_data, .word_valid, .word_ready, .conv_ready, .link_busy, .dummy_pending);
  sadc_dev sadc_dev_inst (.ref_clk, .reset_n, .clk_en(1'b1), .link(lnk), .analog_code, .shutdown_mode,
    .powered_up, .track_mode, .frame_active);
  // lone converter on a bench-driven link, fixed input code, wakes in shutdown
  sadc_dev #(.PWRUP_SHUT(1'b1)) sadc_dev_inst2 (.ref_clk, .reset_n, .clk_en(clk_en2), .link(lnk2),
    .analog_code(10'h2c3),
    .shutdown_mode(shut2), .powered_up(pwr2), .track_mode(), .frame_active());
  sadc_monitor sadc_monitor_inst (.ref_clk, .reset_n, .frame_sel_n(lnk.frame_sel_n), .sclk(lnk.sclk),
    .serial_result_out(lnk.serial_result_out), .serial_result_oe(lnk.serial_result_oe));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // watchdog far above the run length, so a stuck handshake still ends the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      $display("timeout");
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // head of the buffer must hold the word, then one ready cycle takes it
  task automatic pop(input logic [9:0] exp);
    chk("word", {word_valid, word_data}, {1'b1, exp});
    word_ready <= 1'b1;
    tick(1);
    word_ready <= 1'b0;
    tick(1);
  endtask : pop

  // one host frame; want says whether a word must come out of it
  task automatic host_frame(input logic [9:0] code, input logic want);
    analog_code <= code;
    conv_req <= 1'b1;
    while (lnk.frame_sel_n !== 1'b0) tick(1);
    conv_req <= 1'b0;
    tick(8);
    chk("active", {frame_active, shutdown_mode, track_mode}, 3'b100);
    tick(242);
    chk("hold13", track_mode, 1'b0);
    tick(25);
    chk("track", track_mode, 1'b1);
    while (lnk.frame_sel_n !== 1'b1) tick(1);
    tick(4);
    chk("pwr", powered_up, 1'b1);
    if (want) pop(code);
    else chk("none", word_valid, 1'b0);
  endtask : host_frame

  // bench frame on the second link, select raised after the given falls
  task automatic lone_frame(input int falls, input logic shut_exp);
    logic [14:0] cap;
    logic        was_pwr;
    cap = 15'h0000;
    was_pwr = pwr2;
    lnk2.frame_sel_n <= 1'b0;
    tick(LINK2_HALF);
    for (int i = 1; i <= falls; i++) begin
      lnk2.sclk <= 1'b0;
      tick(LINK2_HALF);
      lnk2.sclk <= 1'b1;
      tick(LINK2_HALF);
      if (i < 16) cap = {cap[13:0], lnk2.serial_result_out_line};
    end
    if (falls == 16) chk("rel16", lnk2.serial_result_oe, 1'b0);
    if (falls == 16 && was_pwr) chk("bits", cap, {2'b00, 10'h2c3, 3'b000});
    lnk2.frame_sel_n <= 1'b1;
    tick(20);
    chk("rel", lnk2.serial_result_oe, 1'b0);
    chk("mode2", shut2, shut_exp);
    if (falls == 16) chk("pwr2", pwr2, 1'b1);
    if (shut_exp) tick(200);
    if (shut_exp) chk("hold2", shut2, 1'b1);
  endtask : lone_frame

  initial begin
    reset_n = 1'b0;
    conv_req = 1'b0;
    shutdown_req = 1'b0;
    word_ready = 1'b0;
    analog_code = 10'h000;
    lnk2.frame_sel_n = 1'b1;
    lnk2.sclk = 1'b1;
    clk_en2 = 1'b1;
    tick(4);
    reset_n <= 1'b1;
    tick(2);
    chk("rst", {shutdown_mode, powered_up, word_valid, dummy_pending}, 4'b0001);
    chk("rst2", shut2, 1'b1);
    $display("test reset done");
    host_frame(10'h155, 1'b0);
    chk("dummy", dummy_pending, 1'b0);
    foreach (CODES[i]) host_frame(CODES[i], 1'b1);
    $display("test codes done");
    // shutdown frame from the host, then a wake that must be discarded
    shutdown_req <= 1'b1;
    while (lnk.frame_sel_n !== 1'b0) tick(1);
    shutdown_req <= 1'b0;
    while (lnk.frame_sel_n !== 1'b1) tick(1);
    tick(6);
    chk("shut", {shutdown_mode, lnk.serial_result_oe}, 2'b10);
    tick(300);
    chk("stay", {shutdown_mode, dummy_pending}, 2'b11);
    host_frame(10'h3ff, 1'b0);
    host_frame(10'h0aa, 1'b1);
    $display("test shutdown done");
    // receiver stalls: buffer fills, host refuses more frames, then drains
    analog_code <= 10'h0f0;
    conv_req <= 1'b1;
    while (word_valid !== 1'b1) tick(1);
    analog_code <= 10'h30f;
    while (conv_ready !== 1'b0) tick(1);
    tick(1000);
    chk("refuse", {link_busy, lnk.frame_sel_n}, 2'b01);
    conv_req <= 1'b0;
    tick(1);
    pop(10'h0f0);
    pop(10'h30f);
    chk("empty", {word_valid, conv_ready}, 2'b01);
    $display("test buffer done");
    foreach (FALLS[i]) lone_frame(FALLS[i], SHUT[i]);
    // a frozen converter must ignore a whole frame, then act on the next one
    clk_en2 <= 1'b0;
    lone_frame(4, 1'b0);
    clk_en2 <= 1'b1;
    tick(2);
    lone_frame(4, 1'b1);
    $display("test abort done");
    wrap_up();
  end
endmodule : tb
